// [hdl/hotplug_defines.svh]
`ifndef HOTPLUG_DEFINES_SVH
`define HOTPLUG_DEFINES_SVH
// ============================================================
// Register byte addresses
`define HP_ADDR_CTL 16'h0c00
`define HP_ADDR_STS 16'h0c01
`define HP_ADDR_INT_EN 16'h0c02
`define HP_ADDR_QUEUE 16'h0c03
`define HP_ADDR_MIN 16'h0c04
`define HP_ADDR_MAX 16'h0c05
`define HP_ADDR_HIGH_LO 16'h0c06
`define HP_ADDR_HIGH_HI 16'h0c07
`define HP_ADDR_LOW_LO 16'h0c08
`define HP_ADDR_LOW_HI 16'h0c09
`define HP_ADDR_GEN 16'h0c0a
// ============================================================
// Control bit positions
`define HP_CTL_ENABLE 0
`define HP_CTL_DIR 1
`define HP_CTL_GEN 2
`define HP_CTL_OUTVAL 3
`define HP_CTL_STATE 7
// Status bit positions
`define HP_STS_PULSE 0
`define HP_STS_FALL 1
`define HP_STS_RISE 2
`define HP_STS_NOT_EMPTY 3
// ============================================================
// Queue codes
`define HP_Q_EMPTY 2'h0
`define HP_Q_RISE 2'h1
`define HP_Q_FALL 2'h2
`define HP_Q_PULSE 2'h3
`define HP_Q_CLEAR 2'h1
// ============================================================
// Timing
`define HP_UNIT_NS 50000
`define HP_CLK_NS 20
`define HP_TICK_CYCLES (`HP_UNIT_NS / `HP_CLK_NS)
`define HP_FIXED_UNITS 17'h00002
`define HP_CNT_MAX 17'h1ffff
`endif

// [hdl/hotplug_event_detector.sv]
`timescale 1ns/10ps
`include "hotplug_defines.svh"
// ============================================================
// Hot-plug line monitor and pulse generator
module hotplug_event_detector
	import hotplug_pkg::*;
#(
	parameter int TICK_CYCLES = `HP_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port, byte wide
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Hot-plug pin
	input wire logic hotplug_line_in,
	output logic hotplug_line_out,
	output logic hotplug_line_oe,
	// Interrupt
	output logic irq
);

	// ============================================================
	// Declarations
	logic [7:0] ctl_reg; // Control bits as stored
	logic [3:0] status; // Sticky status flags
	logic [3:0] int_en; // Interrupt enables
	queue_code_t queue [4]; // Event queue fields
	logic [1:0] wptr; // Next field to fill
	logic [7:0] pulse_min_time; // Pulse minimum
	logic [7:0] pulse_max_time; // Pulse maximum
	logic [15:0] high_detect_time; // High detect time
	logic [15:0] low_detect_time; // Low detect time
	logic [7:0] pulse_generate_time; // Generated pulse length
	logic [15:0] tick_cnt; // Timebase divider
	logic tick; // One cycle per 50 us
	logic sync_a; // First synchroniser stage
	logic line_s; // Synchronised pin level
	logic level_d; // Previous synchronised level
	logic [16:0] cnt; // Ticks at present level
	det_state_t det_state; // Qualifier state
	logic [7:0] gen_cnt; // Ticks of generated pulse
	logic enabled; // Function enabled
	logic dir_out; // Pin is an output
	logic detecting; // Input detection active
	logic ev_rise; // Rising event this cycle
	logic ev_fall; // Falling event this cycle
	logic ev_pulse; // Short pulse event this cycle
	logic ev_any; // Any event this cycle
	queue_code_t ev_code; // Code of this event
	logic gen_done; // Generated pulse finished
	logic [3:0] q_clear; // Fields being cleared now
	logic store; // Event goes into the queue
	logic [16:0] thr_high; // Rising threshold in ticks
	logic [16:0] thr_low; // Falling threshold in ticks
	logic [16:0] thr_min; // Pulse minimum in ticks
	logic [16:0] thr_max; // Pulse maximum in ticks
	logic [7:0] queue_view; // Queue as software sees it
	logic wr_ctl, wr_sts, wr_en, wr_q; // Write decodes

	// ============================================================
	// Helpers
	// Programmed units plus the fixed 100 us, in ticks
	function automatic logic [16:0] to_ticks(input logic [15:0] v);
		to_ticks = {1'b0, v} + `HP_FIXED_UNITS;
	endfunction

	// Address match with write strobe
	function automatic logic wr_hit(input logic [15:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	// ============================================================
	// Decodes and thresholds
	assign enabled = ctl_reg[`HP_CTL_ENABLE];
	assign dir_out = ctl_reg[`HP_CTL_DIR];
	assign detecting = enabled && !dir_out;
	assign wr_ctl = wr_hit(`HP_ADDR_CTL);
	assign wr_sts = wr_hit(`HP_ADDR_STS);
	assign wr_en = wr_hit(`HP_ADDR_INT_EN);
	assign wr_q = wr_hit(`HP_ADDR_QUEUE);
	assign thr_high = to_ticks(high_detect_time);
	assign thr_low = to_ticks(low_detect_time);
	assign thr_min = to_ticks({8'h00, pulse_min_time});
	assign thr_max = to_ticks({8'h00, pulse_max_time});

	// ============================================================
	// Timebase
	// Divider making a one-cycle tick every 50 us
	always_ff @(posedge clk) begin
		if (srst || tick) begin
			tick_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end
	assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

	// ============================================================
	// Pin input
	// Two-stage synchroniser ahead of all qualification
	always_ff @(posedge clk) begin
		if (srst) begin
			sync_a <= 1'b0;
			line_s <= 1'b0;
			level_d <= 1'b0;
		end else begin
			sync_a <= hotplug_line_in;
			line_s <= sync_a;
			level_d <= line_s;
		end
	end

	// Ticks spent at the present level, saturating
	always_ff @(posedge clk) begin
		if (srst || !detecting || (line_s != level_d)) begin
			cnt <= 17'h00000;
		end else if (tick && (cnt != `HP_CNT_MAX)) begin
			cnt <= cnt + 17'h00001;
		end
	end

	// ============================================================
	// Event classification
	always_comb begin
		ev_rise = 1'b0;
		ev_fall = 1'b0;
		ev_pulse = 1'b0;
		unique case (det_state)
			DET_IDLE: begin
				// Nothing qualified while disabled
			end
			DET_LOW: begin
				// Line back high long enough
				ev_rise = line_s && (line_s == level_d)
					&& (cnt >= thr_high);
			end
			DET_HIGH: begin
				// Line low long enough is a falling event
				ev_fall = !line_s && (line_s == level_d)
					&& (cnt >= thr_low);
				// Low period ending inside the pulse window
				ev_pulse = line_s && !level_d
					&& (cnt >= thr_min)
					&& (cnt <= thr_max);
			end
		endcase
	end
	assign ev_any = ev_rise || ev_fall || ev_pulse;

	// Event code for the queue
	always_comb begin
		if (ev_rise) begin
			ev_code = `HP_Q_RISE;
		end else if (ev_fall) begin
			ev_code = `HP_Q_FALL;
		end else if (ev_pulse) begin
			ev_code = `HP_Q_PULSE;
		end else begin
			ev_code = `HP_Q_EMPTY;
		end
	end

	// Qualifier state; a fresh enable starts from low
	always_ff @(posedge clk) begin
		if (srst || !detecting) begin
			det_state <= DET_IDLE;
		end else begin
			unique case (det_state)
				DET_IDLE: det_state <= DET_LOW;
				DET_LOW: begin
					if (ev_rise) begin
						det_state <= DET_HIGH;
					end
				end
				DET_HIGH: begin
					if (ev_fall) begin
						det_state <= DET_LOW;
					end
				end
			endcase
		end
	end

	// ============================================================
	// Event queue
	// Fields that software clears by writing the clear code
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			q_clear[i] = wr_q
				&& (reg_wdata[2*i +: 2] == `HP_Q_CLEAR);
		end
	end

	// Store only into a free field; a clear this cycle frees it
	assign store = ev_any && ((queue[wptr] == `HP_Q_EMPTY)
		|| q_clear[wptr]);

	// Queue fields; a new event wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (srst || !enabled) begin
			for (int i = 0; i < 4; i++) begin
				queue[i] <= `HP_Q_EMPTY;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (store && (wptr == 2'(i))) begin
					queue[i] <= ev_code;
				end else if (q_clear[i]) begin
					queue[i] <= `HP_Q_EMPTY;
				end
			end
		end
	end

	// Write pointer moves only forward, wrapping after three
	always_ff @(posedge clk) begin
		if (srst || !enabled) begin
			wptr <= 2'h0;
		end else if (store) begin
			wptr <= wptr + 2'h1;
		end
	end

	// Queue hidden when disabled or driving the pin
	assign queue_view = detecting ? {queue[3], queue[2], queue[1],
		queue[0]} : 8'h00;

	// ============================================================
	// Pulse generator
	// Counts ticks of the low pulse; zero length ends at once
	always_ff @(posedge clk) begin
		if (srst || !ctl_reg[`HP_CTL_GEN]) begin
			gen_cnt <= 8'h00;
		end else if (tick && !gen_done) begin
			gen_cnt <= gen_cnt + 8'h01;
		end
	end
	assign gen_done = ctl_reg[`HP_CTL_GEN]
		&& (gen_cnt >= pulse_generate_time);

	// ============================================================
	// Control register
	// Generate bit self-clears; it only sticks in output mode
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl_reg <= 8'h00;
		end else if (wr_ctl) begin
			ctl_reg <= {4'h0, reg_wdata[3:0]};
		end else if (gen_done || !(enabled && dir_out)) begin
			ctl_reg[`HP_CTL_GEN] <= 1'b0;
		end
	end

	// ============================================================
	// Status register
	// Sticky flags; set wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (srst || !enabled) begin
			status <= 4'h0;
		end else begin
			if (ev_rise) begin
				status[`HP_STS_RISE] <= 1'b1;
			end else if (wr_sts && reg_wdata[`HP_STS_RISE]) begin
				status[`HP_STS_RISE] <= 1'b0;
			end
			if (ev_fall) begin
				status[`HP_STS_FALL] <= 1'b1;
			end else if (wr_sts && reg_wdata[`HP_STS_FALL]) begin
				status[`HP_STS_FALL] <= 1'b0;
			end
			if (ev_pulse || gen_done) begin
				status[`HP_STS_PULSE] <= 1'b1;
			end else if (wr_sts && reg_wdata[`HP_STS_PULSE]) begin
				status[`HP_STS_PULSE] <= 1'b0;
			end
			if (store) begin
				status[`HP_STS_NOT_EMPTY] <= 1'b1;
			end else if (reg_rd && (reg_addr == `HP_ADDR_QUEUE)) begin
				status[`HP_STS_NOT_EMPTY] <= 1'b0;
			end
		end
	end

	// ============================================================
	// Enable and timing registers
	// Interrupt enables, upper bits reserved
	always_ff @(posedge clk) begin
		if (srst) begin
			int_en <= 4'h0;
		end else if (wr_en) begin
			int_en <= reg_wdata[3:0];
		end
	end

	// Timing values, held constant by software while enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			pulse_min_time <= 8'h00;
			pulse_max_time <= 8'h00;
			high_detect_time <= 16'h0000;
			low_detect_time <= 16'h0000;
			pulse_generate_time <= 8'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`HP_ADDR_MIN: pulse_min_time <= reg_wdata;
				`HP_ADDR_MAX: pulse_max_time <= reg_wdata;
				`HP_ADDR_HIGH_LO: high_detect_time[7:0] <= reg_wdata;
				`HP_ADDR_HIGH_HI: high_detect_time[15:8] <= reg_wdata;
				`HP_ADDR_LOW_LO: low_detect_time[7:0] <= reg_wdata;
				`HP_ADDR_LOW_HI: low_detect_time[15:8] <= reg_wdata;
				`HP_ADDR_GEN: pulse_generate_time <= reg_wdata;
				default: begin
					// Other addresses hold no timing value
				end
			endcase
		end
	end

	// ============================================================
	// Read data
	// Registered read answer; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`HP_ADDR_CTL: reg_rdata <= {enabled && line_s, 3'h0,
					ctl_reg[`HP_CTL_OUTVAL] && dir_out,
					ctl_reg[`HP_CTL_GEN] && dir_out,
					ctl_reg[1:0]};
				`HP_ADDR_STS: reg_rdata <= {4'h0, status};
				`HP_ADDR_INT_EN: reg_rdata <= {4'h0, int_en};
				`HP_ADDR_QUEUE: reg_rdata <= queue_view;
				`HP_ADDR_MIN: reg_rdata <= pulse_min_time;
				`HP_ADDR_MAX: reg_rdata <= pulse_max_time;
				`HP_ADDR_HIGH_LO: reg_rdata <= high_detect_time[7:0];
				`HP_ADDR_HIGH_HI: reg_rdata <= high_detect_time[15:8];
				`HP_ADDR_LOW_LO: reg_rdata <= low_detect_time[7:0];
				`HP_ADDR_LOW_HI: reg_rdata <= low_detect_time[15:8];
				`HP_ADDR_GEN: reg_rdata <= pulse_generate_time;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ============================================================
	// Pin drive and interrupt
	// Output mode drives the set level, low while a pulse runs
	always_ff @(posedge clk) begin
		if (srst) begin
			hotplug_line_oe <= 1'b0;
			hotplug_line_out <= 1'b0;
		end else begin
			hotplug_line_oe <= enabled && dir_out;
			hotplug_line_out <= ctl_reg[`HP_CTL_OUTVAL]
				&& !(ctl_reg[`HP_CTL_GEN] && !gen_done);
		end
	end

	// Flags gated by enables, then combined
	assign irq = |(status & int_en);

endmodule

// [hdl/hotplug_pkg.sv]
// ============================================================
// Shared types
package hotplug_pkg;
	// Input qualifier state, Gray along idle-low-high
	typedef enum logic [1:0] {
		DET_IDLE = 2'h0,
		DET_LOW = 2'h1,
		DET_HIGH = 2'h3
	} det_state_t;
	// Queue field code
	typedef logic [1:0] queue_code_t;
endpackage

// [testbench/hotplug_properties.sv]
`timescale 1ns/10ps
`include "hotplug_defines.svh"
// ============================================================
// Port-level checks of the hot-plug block
module hotplug_checker #(
	parameter int TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Pin and interrupt
	input wire logic hotplug_line_in,
	input wire logic hotplug_line_out,
	input wire logic hotplug_line_oe,
	input wire logic irq
);
	logic en_s; // Shadow of enable
	logic dir_s; // Shadow of direction
	logic out_s; // Shadow of output value
	logic [3:0] ien_s; // Shadow of interrupt enables
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ============================================================
	// Shadows follow software writes
	always_ff @(posedge clk) begin
		if (srst) begin
			{en_s, dir_s, out_s, ien_s} <= 7'h00;
		end else if (reg_wr && reg_addr == `HP_ADDR_CTL) begin
			{en_s, dir_s, out_s} <= {reg_wdata[0], reg_wdata[1], reg_wdata[3]};
		end else if (reg_wr && reg_addr == `HP_ADDR_INT_EN) begin
			ien_s <= reg_wdata[3:0];
		end
	end
	// ============================================================
	// Assertions
	chk_queue_masked: assert property (
		reg_rd && reg_addr == `HP_ADDR_QUEUE && (!en_s || dir_s)
		|=> reg_rdata == 8'h00) else $error("queue read not zero");
	chk_enable_bits: assert property (
		reg_rd && reg_addr == `HP_ADDR_INT_EN |=> reg_rdata[7:4] == 4'h0)
		else $error("reserved enable bits set");
	chk_irq_masked: assert property (
		ien_s == 4'h0 && $past(ien_s) == 4'h0 |-> !irq)
		else $error("irq with all enables off");
	chk_dir_input: assert property (
		!dir_s && !$past(dir_s) |-> !hotplug_line_oe)
		else $error("pin driven in input mode");
	chk_dir_output: assert property (
		en_s && dir_s && $past(en_s && dir_s) |-> hotplug_line_oe)
		else $error("pin not driven in output mode");
	chk_gen_restore: assert property (
		hotplug_line_oe && out_s && $fell(hotplug_line_out)
		|-> ##[1:1000] hotplug_line_out) else $error("pulse not restored");
	chk_ctl_gen_read: assert property (
		reg_rd && reg_addr == `HP_ADDR_CTL && !dir_s
		|=> reg_rdata[3:2] == 2'h0) else $error("output bits read nonzero");
	chk_state_off: assert property (
		reg_rd && reg_addr == `HP_ADDR_CTL && !en_s |=> !reg_rdata[7])
		else $error("pin state shown while disabled");
	chk_reset_quiet: assert property (
		$past(srst) |-> !irq && !hotplug_line_oe && reg_rdata == 8'h00)
		else $error("outputs active after reset");
	// Pin level steady over both synchroniser stages shows in the read
	chk_state_read: assert property (
		reg_rd && reg_addr == `HP_ADDR_CTL && en_s
		&& hotplug_line_in == $past(hotplug_line_in)
		&& hotplug_line_in == $past(hotplug_line_in, 2)
		|=> reg_rdata[7] == $past(hotplug_line_in))
		else $error("pin state read wrong");
endmodule
bind hotplug_event_detector hotplug_checker #(.TICK_CYCLES(TICK_CYCLES))
	chk_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.hotplug_line_in(hotplug_line_in), .hotplug_line_out(hotplug_line_out),
	.hotplug_line_oe(hotplug_line_oe), .irq(irq));

// [testbench/hotplug_sink_model.sv]
`timescale 1ns/10ps
// ============================================================
// Far-end sink sharing the hot-plug line
module hotplug_sink_model (
	// Device side of the line
	input wire logic dut_out,
	input wire logic dut_oe,
	// Sink drive request
	input wire logic sink_en,
	input wire logic sink_val,
	// Resolved wire level
	output logic line
);
	// Device drive wins; a released line falls to its pull-down
	assign line = dut_oe ? dut_out : (sink_en ? sink_val : 1'b0);
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "hotplug_defines.svh"
// ============================================================
// Self-checking bench of the hot-plug block
module tb_top;
	logic clk;
	logic srst;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] got; // Last read value
	logic hotplug_line_out;
	logic hotplug_line_oe;
	logic irq;
	logic line; // Resolved pin level
	logic sink_en;
	logic sink_val;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	// Rows: address, write data, expected read back
	logic [31:0] rows [6] = '{32'h0c02ff0f, 32'h0c040101, 32'h0c050303,
		32'h0c080a0a, 32'h0c0a0303, 32'h0c0b5a00};
	// ============================================================
	// Design and far-end sink
	hotplug_event_detector #(.TICK_CYCLES(4)) dut_u (.clk(clk),
		.srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hotplug_line_in(line),
		.hotplug_line_out(hotplug_line_out),
		.hotplug_line_oe(hotplug_line_oe), .irq(irq));
	hotplug_sink_model sink_u (.dut_out(hotplug_line_out),
		.dut_oe(hotplug_line_oe), .sink_en(sink_en), .sink_val(sink_val),
		.line(line));
	// ============================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			stop_test();
		end
	end
	// ============================================================
	// Bus and compare tasks
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic chk(input logic [7:0] e);
		checks++;
		if (got !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, e);
		end
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		got = reg_rdata;
		chk(e);
	endtask
	task automatic pin(input logic [7:0] p, input logic [7:0] e);
		got = p;
		chk(e);
	endtask
	task automatic hold(input logic v, input int c);
		sink_val = v;
		repeat (c) @(negedge clk);
	endtask
	task automatic apply_rows();
		for (int i = 0; i < 6; i++) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rc(rows[i][31:16], rows[i][7:0]);
		end
	endtask
	task automatic stop_test();
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		{srst, reg_wr, reg_rd, reg_addr, reg_wdata} = 27'h4000000;
		{sink_en, sink_val, got} = 10'h200;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		apply_rows();
		// Mid-run reset returns every register to zero
		srst = 1'b1;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		for (int a = 16'h0c00; a <= 16'h0c0b; a++) begin
			rc(a[15:0], 8'h00);
		end
		apply_rows();
		// Input mode: rise, short, pulse, long, fall, rise
		wr(`HP_ADDR_CTL, 8'h01);
		hold(1'b0, 20);
		hold(1'b1, 20);
		hold(1'b0, 4);
		hold(1'b1, 20);
		hold(1'b0, 16);
		hold(1'b1, 20);
		hold(1'b0, 32);
		hold(1'b1, 20);
		hold(1'b0, 60);
		hold(1'b1, 20);
		rc(`HP_ADDR_STS, 8'h0f);
		pin({7'h00, irq}, 8'h01);
		wr(`HP_ADDR_INT_EN, 8'h00);
		pin({7'h00, irq}, 8'h00);
		wr(`HP_ADDR_INT_EN, 8'h04);
		pin({7'h00, irq}, 8'h01);
		rc(`HP_ADDR_QUEUE, 8'h6d);
		rc(`HP_ADDR_STS, 8'h07);
		wr(`HP_ADDR_STS, 8'h07);
		rc(`HP_ADDR_STS, 8'h00);
		pin({7'h00, irq}, 8'h00);
		// Full queue drops, then field zero is refilled after wrap
		hold(1'b0, 60);
		rc(`HP_ADDR_QUEUE, 8'h6d);
		wr(`HP_ADDR_QUEUE, 8'h01);
		rc(`HP_ADDR_QUEUE, 8'h6c);
		hold(1'b1, 20);
		rc(`HP_ADDR_QUEUE, 8'h6d);
		// Pointer sits on an occupied field although field two is free
		wr(`HP_ADDR_QUEUE, 8'h10);
		hold(1'b0, 60);
		rc(`HP_ADDR_QUEUE, 8'h4d);
		// Output mode hides the queue and drives the pin
		sink_en = 1'b0;
		wr(`HP_ADDR_CTL, 8'h03);
		rc(`HP_ADDR_QUEUE, 8'h00);
		pin({7'h00, hotplug_line_oe}, 8'h01);
		// Generated pulse: three ticks of four cycles, one tick early
		wr(`HP_ADDR_CTL, 8'h00);
		// Idle level high first, so the pulse is a real fall
		wr(`HP_ADDR_CTL, 8'h0b);
		wr(`HP_ADDR_CTL, 8'h0f);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			n += !hotplug_line_out;
		end
		pin({7'h00, n >= 8 && n <= 13}, 8'h01);
		pin({7'h00, hotplug_line_out}, 8'h01);
		rc(`HP_ADDR_STS, 8'h01);
		rc(`HP_ADDR_CTL, 8'h8b);
		stop_test();
	end
endmodule
